// ==== src/bia_pkg.sv ====
// package: constants and carrier types for barrier i/o, alarm and diagnostics
package bia_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_MS_CYC = CLK_HZ / 1000;
    localparam int unsigned OBSTRUCT_S = 30;
    localparam int unsigned WRONG_WAY_S = 15;
    localparam int unsigned COUNT_PULSE_MS = 400;
    localparam int unsigned DOT_PERIOD_MS = 2000;
    localparam int unsigned DISP_STEP_S = 2;
    localparam int unsigned OBSTRUCT_MS = OBSTRUCT_S * 1000;
    localparam int unsigned WRONG_WAY_MS = WRONG_WAY_S * 1000;
    localparam int unsigned DOT_HALF_MS = DOT_PERIOD_MS / 2;
    localparam int unsigned DISP_STEP_MS = DISP_STEP_S * 1000;
    localparam int unsigned LOITER_MS = 5000;
    localparam int unsigned DEB_MS = 5;
    localparam logic [5:0] RELAY_RESET = 6'h00;
    localparam logic [3:0] LAMP_RESET = 4'h0;
    localparam logic [7:0] SEG_BLANK = 8'h00;
    localparam logic [7:0] SEG_DP = 8'h80;
    localparam logic [7:0] SEG_U = 8'h1c;
    localparam logic [7:0] SEG_E = 8'h79;

    typedef struct packed {
        logic emergency_ok;
        logic open_entry;
        logic open_exit;
        logic entry_outer_beam;
        logic entry_inner_beam;
        logic exit_inner_beam;
        logic exit_outer_beam;
        logic wing_beam_a;
        logic wing_beam_b;
    } bia_inputs_t;

    typedef struct packed {
        logic global_error_ok;
        logic tailgate;
        logic wrong_way;
        logic count_pulse;
        logic inhibit_entry_reader;
        logic inhibit_exit_reader;
    } bia_relays_t;

    typedef struct packed {
        logic entry_red;
        logic entry_green;
        logic exit_red;
        logic exit_green;
    } bia_lamps_t;

    typedef enum logic [1:0] {
        DSP_LETTER,
        DSP_FIRST,
        DSP_SECOND,
        DSP_PAUSE
    } bia_disp_t;
endpackage

// ==== src/bia_sync_deb.sv ====
// module: two-flop synchroniser and debounce filter for one input
`timescale 1ns/1ps
`default_nettype none
module bia_sync_deb
    import bia_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ms_tick,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [2:0] cnt;
        logic lvl;
    } bia_deb_st_t;

    bia_deb_st_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin;
        st_next.s2 = st_reg.s1;
        if (st_reg.s2 == st_reg.lvl) begin
            st_next.cnt = 3'h0;
        end else if (ms_tick) begin
            if (st_reg.cnt == 3'(DEB_MS - 1)) begin
                st_next.lvl = st_reg.s2;
                st_next.cnt = 3'h0;
            end else begin
                st_next.cnt = st_reg.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.lvl;
endmodule
`default_nettype wire

// ==== src/bia_top.sv ====
// module: barrier i/o evaluation, alarm relays, lamps and diagnosis display
`timescale 1ns/1ps
`default_nettype none
module bia_top
    import bia_pkg::*;
#(
    parameter int unsigned MS_CYCLES = TICK_MS_CYC
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire bia_inputs_t pins,
    input wire logic allow_entry,
    input wire logic allow_exit,
    input wire logic show_version,
    input wire logic ext_fault,
    input wire logic [3:0] version_hi,
    input wire logic [3:0] version_lo,
    input wire logic [3:0] error_hi,
    input wire logic [3:0] error_lo,
    output bia_relays_t relays,
    output bia_lamps_t lamps,
    output logic motor_power_en,
    output logic wings_open,
    output logic [5:0] beam_alarm,
    output logic [7:0] segments
);
    localparam int NB = 6;

    typedef struct packed {
        logic [15:0] pre;
        logic tick;
        logic [NB-1:0][14:0] obst;
        logic [NB-1:0] balarm;
        logic open_reg;
        logic dir_exit;
        logic passing;
        logic [13:0] ww_cnt;
        logic ww;
        logic [12:0] loiter;
        logic [8:0] cnt_pulse;
        logic [10:0] dot_cnt;
        logic dot;
        logic [10:0] step_cnt;
        bia_disp_t dstep;
        logic mode_err;
        logic mode_ver;
        bia_relays_t rel;
        bia_lamps_t lmp;
        logic motor;
        logic wings;
        logic [7:0] seg;
    } bia_st_t;

    bia_st_t st_reg, st_next;
    bia_inputs_t clean;
    logic [NB-1:0] beam_clear;

    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_in
            bia_sync_deb u_deb (
                .ref_clk(ref_clk),
                .reset(reset),
                .ms_tick(st_reg.tick),
                .pin(pins[gi]),
                .level(clean[gi])
            );
        end
    endgenerate

    // high level is a clear beam; a dead cell or wire reads interrupted
    assign beam_clear = {clean.entry_outer_beam, clean.entry_inner_beam, clean.exit_inner_beam,
                         clean.exit_outer_beam, clean.wing_beam_a, clean.wing_beam_b};

    function automatic logic [7:0] seg_digit(input logic [3:0] d);
        logic [7:0] s;
        s = SEG_BLANK;
        unique case (d)
            4'h0: s = 8'h3f;
            4'h1: s = 8'h06;
            4'h2: s = 8'h5b;
            4'h3: s = 8'h4f;
            4'h4: s = 8'h66;
            4'h5: s = 8'h6d;
            4'h6: s = 8'h7d;
            4'h7: s = 8'h07;
            4'h8: s = 8'h7f;
            4'h9: s = 8'h6f;
            default: s = 8'h40;
        endcase
        return s;
    endfunction

    logic entry_zone_busy, exit_zone_busy, wing_busy, err_now, lane_multi;
    logic tick;
    logic [2:0] occupied;

    always_comb begin
        st_next = st_reg;
        tick = st_reg.tick;
        entry_zone_busy = !beam_clear[5] || !beam_clear[4];
        exit_zone_busy = !beam_clear[3] || !beam_clear[2];
        wing_busy = !beam_clear[1] || !beam_clear[0];
        occupied = {2'b00, entry_zone_busy} + {2'b00, wing_busy} + {2'b00, exit_zone_busy};
        lane_multi = occupied > 3'd1;
        err_now = !clean.emergency_ok || ext_fault || (|st_reg.balarm);
        // millisecond prescaler drives every timer
        if (st_reg.pre == 16'(MS_CYCLES - 1)) begin
            st_next.pre = 16'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.pre = st_reg.pre + 16'h0001;
            st_next.tick = 1'b0;
        end
        for (int i = 0; i < NB; i++) begin
            if (beam_clear[i]) begin
                st_next.obst[i] = 15'h0000;
                st_next.balarm[i] = 1'b0;
            end else if (tick) begin
                if (st_reg.obst[i] >= 15'(OBSTRUCT_MS)) begin
                    st_next.balarm[i] = 1'b1;
                end else begin
                    st_next.obst[i] = st_reg.obst[i] + 15'h0001;
                end
            end
        end
        // opening requests
        if (!st_reg.open_reg) begin
            if (clean.open_entry && allow_entry) begin
                st_next.open_reg = 1'b1;
                st_next.dir_exit = 1'b0;
            end else if (clean.open_exit && allow_exit) begin
                st_next.open_reg = 1'b1;
                st_next.dir_exit = 1'b1;
            end
            st_next.passing = 1'b0;
        end else begin
            if (wing_busy) begin
                st_next.passing = 1'b1;
            end
            // apart from emergency loss, close only once the wing zone was used and is clear again
            if (st_reg.passing && !wing_busy) begin
                st_next.open_reg = 1'b0;
                st_next.cnt_pulse = 9'(COUNT_PULSE_MS);
            end
        end
        if (!clean.emergency_ok) begin
            st_next.open_reg = 1'b0;
            st_next.passing = 1'b0;
        end
        if (st_reg.cnt_pulse != 9'h000 && tick) begin
            st_next.cnt_pulse = st_reg.cnt_pulse - 9'h001;
        end
        // wrong way: forbidden-side entry or loitering while closed
        if (!st_reg.open_reg && entry_zone_busy && tick) begin
            if (st_reg.loiter != 13'(LOITER_MS)) begin
                st_next.loiter = st_reg.loiter + 13'h0001;
            end
        end else if (!entry_zone_busy) begin
            st_next.loiter = 13'h0000;
        end
        if ((st_reg.open_reg && !st_reg.dir_exit && !beam_clear[2] && beam_clear[5])
            || (st_reg.open_reg && st_reg.dir_exit && !beam_clear[5] && beam_clear[2])) begin
            st_next.ww = 1'b1;
            st_next.ww_cnt = 14'h0000;
        end
        // raise once on reaching the limit, so the 15 s cancel is not undone
        if (!st_reg.open_reg && entry_zone_busy && tick && st_reg.loiter == 13'(LOITER_MS - 1) && !st_reg.ww) begin
            st_next.ww = 1'b1;
            st_next.ww_cnt = 14'h0000;
        end
        if (st_reg.ww) begin
            if (!entry_zone_busy && !exit_zone_busy) begin
                st_next.ww = 1'b0;
            end else if (tick) begin
                if (st_reg.ww_cnt == 14'(WRONG_WAY_MS - 1)) begin
                    st_next.ww = 1'b0;
                end else begin
                    st_next.ww_cnt = st_reg.ww_cnt + 14'h0001;
                end
            end
        end
        // relays: fail-safe global error is energised when healthy
        st_next.rel.global_error_ok = !err_now;
        st_next.rel.tailgate = st_reg.open_reg && lane_multi;
        st_next.rel.wrong_way = st_reg.ww;
        st_next.rel.count_pulse = st_reg.cnt_pulse != 9'h000;
        st_next.rel.inhibit_entry_reader = st_reg.open_reg && st_reg.dir_exit;
        st_next.rel.inhibit_exit_reader = st_reg.open_reg && !st_reg.dir_exit;
        st_next.motor = clean.emergency_ok;
        st_next.wings = st_next.open_reg || !st_next.motor;
        st_next.lmp.entry_green = allow_entry && (!st_reg.open_reg || !st_reg.dir_exit);
        st_next.lmp.entry_red = !(allow_entry && (!st_reg.open_reg || !st_reg.dir_exit));
        st_next.lmp.exit_green = allow_exit && (!st_reg.open_reg || st_reg.dir_exit);
        st_next.lmp.exit_red = !(allow_exit && (!st_reg.open_reg || st_reg.dir_exit));
        // dot toggles every second for a 0.5 Hz blink
        if (tick) begin
            if (st_reg.dot_cnt == 11'(DOT_HALF_MS - 1)) begin
                st_next.dot_cnt = 11'h000;
                st_next.dot = !st_reg.dot;
            end else begin
                st_next.dot_cnt = st_reg.dot_cnt + 11'h001;
            end
        end
        // sequence restarts whenever the display source changes
        st_next.mode_err = err_now;
        st_next.mode_ver = show_version && !err_now;
        if (st_next.mode_err != st_reg.mode_err || st_next.mode_ver != st_reg.mode_ver) begin
            st_next.step_cnt = 11'h000;
            st_next.dstep = DSP_LETTER;
        end else if (tick) begin
            if (st_reg.step_cnt == 11'(DISP_STEP_MS - 1)) begin
                st_next.step_cnt = 11'h000;
                unique case (st_reg.dstep)
                    DSP_LETTER: st_next.dstep = DSP_FIRST;
                    DSP_FIRST: st_next.dstep = DSP_SECOND;
                    DSP_SECOND: st_next.dstep = DSP_PAUSE;
                    DSP_PAUSE: st_next.dstep = DSP_LETTER;
                endcase
            end else begin
                st_next.step_cnt = st_reg.step_cnt + 11'h001;
            end
        end
        if (st_reg.mode_err) begin
            unique case (st_reg.dstep)
                DSP_LETTER: st_next.seg = SEG_E;
                DSP_FIRST: st_next.seg = seg_digit(error_hi);
                DSP_SECOND: st_next.seg = seg_digit(error_lo) | SEG_DP;
                DSP_PAUSE: st_next.seg = SEG_BLANK;
            endcase
        end else if (st_reg.mode_ver) begin
            unique case (st_reg.dstep)
                DSP_LETTER: st_next.seg = SEG_U;
                DSP_FIRST: st_next.seg = seg_digit(version_hi) | SEG_DP;
                DSP_SECOND: st_next.seg = seg_digit(version_lo);
                DSP_PAUSE: st_next.seg = SEG_BLANK;
            endcase
        end else begin
            st_next.seg = st_reg.dot ? SEG_DP : SEG_BLANK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.dstep <= DSP_LETTER;
            st_reg.rel <= RELAY_RESET;
            st_reg.lmp <= LAMP_RESET;
            st_reg.seg <= SEG_BLANK;
        end else begin
            st_reg <= st_next;
        end
    end

    assign relays = st_reg.rel;
    assign lamps = st_reg.lmp;
    assign motor_power_en = st_reg.motor;
    assign wings_open = st_reg.wings;
    assign beam_alarm = st_reg.balarm;
    assign segments = st_reg.seg;

    a_emerg_motor: assert property (@(posedge ref_clk) disable iff (reset)
        !clean.emergency_ok |=> !motor_power_en && wings_open)
        else $error("motor power kept without emergency level");
    a_emerg_priority: assert property (@(posedge ref_clk) disable iff (reset)
        !clean.emergency_ok |=> !st_reg.open_reg)
        else $error("open state survived emergency loss");
    a_global_err: assert property (@(posedge ref_clk) disable iff (reset)
        !clean.emergency_ok |=> !relays.global_error_ok)
        else $error("global error relay stayed energised");
    a_no_close_busy: assert property (@(posedge ref_clk) disable iff (reset)
        st_reg.open_reg && clean.emergency_ok && wing_busy |=> st_reg.open_reg)
        else $error("closed while wing beam interrupted");
    a_count_len: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(st_reg.cnt_pulse != 9'h000) |-> st_reg.cnt_pulse == 9'(COUNT_PULSE_MS))
        else $error("count pulse length wrong");
    a_inhibit_excl: assert property (@(posedge ref_clk) disable iff (reset)
        !(relays.inhibit_entry_reader && relays.inhibit_exit_reader))
        else $error("both readers inhibited");
    a_beam_alarm: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(st_reg.balarm[5]) |-> st_reg.obst[5] == 15'(OBSTRUCT_MS))
        else $error("beam alarm at wrong time");
    a_ww_limit: assert property (@(posedge ref_clk) disable iff (reset)
        st_reg.ww |-> st_reg.ww_cnt < 14'(WRONG_WAY_MS))
        else $error("wrong way alarm overran");
    a_err_display: assert property (@(posedge ref_clk) disable iff (reset)
        st_reg.mode_err && st_reg.dstep == DSP_LETTER |=> segments == SEG_E || $changed(st_reg.mode_err))
        else $error("error letter not shown");
endmodule
`default_nettype wire

// ==== tb/bia_lane_model.sv ====
// lane partner model: card readers, emergency switch and photocells
`timescale 1ns/1ps
`default_nettype none
module bia_lane_model
    import bia_pkg::*;
(
    input wire logic emergency_on,
    input wire logic card_entry,
    input wire logic card_exit,
    input wire logic [5:0] block,
    output bia_inputs_t pins
);
    // healthy cells drive high; a blocked or broken beam reads low
    always_comb begin
        pins.emergency_ok = emergency_on;
        pins.open_entry = card_entry;
        pins.open_exit = card_exit;
        pins.entry_outer_beam = !block[5];
        pins.entry_inner_beam = !block[4];
        pins.exit_inner_beam = !block[3];
        pins.exit_outer_beam = !block[2];
        pins.wing_beam_a = !block[1];
        pins.wing_beam_b = !block[0];
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for barrier i/o, alarm relays and diagnosis display
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bia_pkg::*;
;
    // one tick per cycle keeps the 30 s supervisor within run length
    localparam int MS = 1;
    localparam int GOK = 11, TG = 10, WW = 9, CP = 8, INE = 7, INX = 6;
    localparam int ERD = 5, EGR = 4, XRD = 3, XGR = 2, MOT = 1, WOP = 0;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic emergency_on = 1'b1;
    logic card_entry = 1'b0;
    logic card_exit = 1'b0;
    logic [5:0] block = 6'h00;
    logic show_version = 1'b0;
    logic ext_fault = 1'b0;
    logic allow_exit = 1'b1;
    bia_inputs_t pins;
    bia_relays_t relays;
    bia_lamps_t lamps;
    logic motor_power_en;
    logic wings_open;
    logic [5:0] beam_alarm;
    logic [7:0] segments;
    wire logic [11:0] obs = {relays, lamps, motor_power_en, wings_open};
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    bia_lane_model lane (.emergency_on(emergency_on), .card_entry(card_entry), .card_exit(card_exit),
        .block(block), .pins(pins));

    bia_top #(.MS_CYCLES(MS)) DUT (.ref_clk(ref_clk), .reset(reset), .pins(pins), .allow_entry(1'b1),
        .allow_exit(allow_exit), .show_version(show_version), .ext_fault(ext_fault), .version_hi(4'h1),
        .version_lo(4'h4), .error_hi(4'h0), .error_lo(4'h5), .relays(relays), .lamps(lamps),
        .motor_power_en(motor_power_en), .wings_open(wings_open), .beam_alarm(beam_alarm),
        .segments(segments));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            wrap_up;
        end
    end

    task automatic chk1(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_bit(input int idx, input logic val, input int lim, input string what);
        int i;
        i = 0;
        while (obs[idx] !== val && i < lim) begin
            tick(1);
            i++;
        end
        chk1(obs[idx], val, what);
    endtask

    task automatic set_block(input logic [5:0] b);
        @(posedge ref_clk);
        block <= b;
        #1;
    endtask

    // pulse held well past the debounce filter
    task automatic card(input logic entry_side);
        @(posedge ref_clk);
        if (entry_side) card_entry <= 1'b1;
        else card_exit <= 1'b1;
        tick(20 * MS);
        @(posedge ref_clk);
        card_entry <= 1'b0;
        card_exit <= 1'b0;
        #1;
    endtask

    task automatic seq_check(input logic [7:0] letter, input logic dp1, input logic dp2);
        chk8(segments, letter, "letter");
        tick(2000 * MS);
        chk1(segments[7], dp1, "first dot");
        chk1(|segments[6:0], 1'b1, "first digit");
        tick(2000 * MS);
        chk1(segments[7], dp2, "second dot");
        chk1(|segments[6:0], 1'b1, "second digit");
        tick(2000 * MS);
        chk8(segments, SEG_BLANK, "pause");
        tick(2000 * MS);
        chk8(segments, letter, "repeat");
    endtask

    task automatic t_reset;
        tick(20);
        chk1(|obs, 1'b0, "outputs in reset");
        chk8(segments, SEG_BLANK, "display in reset");
        @(posedge ref_clk);
        reset <= 1'b0;
        wait_bit(GOK, 1'b1, 50, "healthy relay");
        wait_bit(MOT, 1'b1, 50, "motor power");
        chk1(obs[WOP], 1'b0, "closed at start");
        $display("test reset done");
    endtask

    task automatic t_entry;
        int w;
        card(1'b1);
        wait_bit(WOP, 1'b1, 60, "entry open");
        chk1(obs[INX], 1'b1, "exit reader blocked");
        chk1(obs[INE], 1'b0, "entry reader free");
        chk1(obs[EGR] & obs[XRD] & !obs[ERD], 1'b1, "entry lamps");
        set_block(6'h04);
        wait_bit(WW, 1'b1, 60, "wrong way in");
        set_block(6'h00);
        wait_bit(WW, 1'b0, 60, "wrong way cleared");
        set_block(6'h12);
        wait_bit(TG, 1'b1, 60, "tailgate");
        tick(100 * MS);
        chk1(obs[WOP], 1'b1, "held open on wing beam");
        set_block(6'h02);
        wait_bit(TG, 1'b0, 60, "tailgate released");
        set_block(6'h00);
        wait_bit(CP, 1'b1, 60, "count pulse");
        w = 0;
        while (obs[CP] === 1'b1 && w < 1000 * MS) begin
            tick(1);
            w++;
        end
        chk1(w >= 398 * MS && w <= 402 * MS, 1'b1, "count width");
        wait_bit(WOP, 1'b0, 100, "closed after passage");
        $display("test entry done");
    endtask

    task automatic t_exit;
        card(1'b0);
        wait_bit(WOP, 1'b1, 60, "exit open");
        chk1(obs[INE], 1'b1, "entry reader blocked");
        chk1(obs[XGR] & obs[ERD] & !obs[XRD], 1'b1, "exit lamps");
        set_block(6'h01);
        tick(20 * MS);
        set_block(6'h00);
        wait_bit(CP, 1'b1, 60, "exit count");
        wait_bit(WOP, 1'b0, 100, "closed after exit");
        wait_bit(CP, 1'b0, 500 * MS, "count end");
        $display("test exit done");
    endtask

    task automatic t_emergency;
        @(posedge ref_clk);
        emergency_on <= 1'b0;
        wait_bit(MOT, 1'b0, 60, "motor cut");
        chk1(obs[WOP], 1'b1, "wings free");
        chk1(obs[GOK], 1'b0, "global alarm");
        card(1'b1);
        tick(20 * MS);
        chk1(obs[INX], 1'b0, "request ignored");
        @(posedge ref_clk);
        emergency_on <= 1'b1;
        wait_bit(GOK, 1'b1, 60, "healthy again");
        wait_bit(WOP, 1'b0, 60, "closed again");
        $display("test emergency done");
    endtask

    // exit direction not permitted: request ignored, exit cross shown
    task automatic t_refuse;
        @(posedge ref_clk);
        allow_exit <= 1'b0;
        tick(2);
        chk1(obs[XGR], 1'b0, "exit arrow off");
        chk1(obs[XRD], 1'b1, "exit cross on");
        card(1'b0);
        tick(20 * MS);
        chk1(obs[WOP], 1'b0, "exit refused");
        chk1(obs[INE], 1'b0, "entry reader free");
        @(posedge ref_clk);
        allow_exit <= 1'b1;
        $display("test refuse done");
    endtask

    task automatic t_display;
        int i;
        int w;
        i = 0;
        w = 0;
        while (!(segments[7] === 1'b0) && i < 2100 * MS) begin
            tick(1);
            i++;
        end
        while (segments[7] !== 1'b1 && i < 4200 * MS) begin
            tick(1);
            i++;
        end
        while (segments[7] === 1'b1 && w < 2000 * MS) begin
            tick(1);
            w++;
        end
        chk1(w >= 998 * MS && w <= 1002 * MS, 1'b1, "dot half period");
        @(posedge ref_clk);
        show_version <= 1'b1;
        tick(1000 * MS);
        seq_check(SEG_U, 1'b1, 1'b0);
        @(posedge ref_clk);
        show_version <= 1'b0;
        tick(1000 * MS);
        chk1(|segments[6:0], 1'b0, "normal display back");
        @(posedge ref_clk);
        ext_fault <= 1'b1;
        wait_bit(GOK, 1'b0, 60, "fault alarm");
        tick(1000 * MS);
        seq_check(SEG_E, 1'b0, 1'b1);
        @(posedge ref_clk);
        ext_fault <= 1'b0;
        wait_bit(GOK, 1'b1, 60, "fault gone");
        $display("test display done");
    endtask

    // left last: the beam alarm stays pending afterwards
    task automatic t_obstruct;
        set_block(6'h20);
        tick(4000 * MS);
        chk1(obs[WW], 1'b0, "no loiter yet");
        tick(2000 * MS);
        chk1(obs[WW], 1'b1, "loiter alarm");
        tick(15000 * MS);
        chk1(obs[WW], 1'b0, "loiter timed out");
        tick(8000 * MS);
        chk1(beam_alarm[5], 1'b0, "beam ok at 29 s");
        tick(2000 * MS);
        chk1(beam_alarm[5], 1'b1, "beam alarm at 31 s");
        chk1(|beam_alarm[4:0], 1'b0, "other beams quiet");
        chk1(obs[GOK], 1'b0, "beam alarm global");
        $display("test obstruct done");
    endtask

    initial begin
        t_reset;
        t_entry;
        t_exit;
        t_emergency;
        t_refuse;
        t_display;
        t_obstruct;
        wrap_up;
    end
endmodule
`default_nettype wire
